// file: inc/msd_pkg.sv
// Constants and types shared by the memory space decoder
package msd_pkg;
    localparam int          ADDR_W       = 16;
    localparam int          DATA_W       = 8;
    localparam int          ROM_AW       = 15;
    localparam int          EXT_RAM_AW   = 11;
    localparam int          IRAM_AW      = 8;
    localparam int          EXT_RAM_SIZE = 2048;
    localparam int          IRAM_SIZE    = 256;
    localparam int          NUM_DPTR     = 8;
    localparam int          SYNC_W       = 10;
    localparam int          SYNC_FSEL    = 0;
    localparam int          SYNC_ACK     = 1;
    localparam int          SYNC_DATA    = 2;
    localparam logic [15:0] ROM_LIMIT    = 16'h8000;
    localparam logic [15:0] EXT_RAM_BASE = 16'hF800;
    localparam logic [7:0]  SFR_BASE     = 8'h80;
    localparam logic [7:0]  BLOCK_DATA   = 8'h00;

    typedef enum logic [2:0]
    {
        OP_FETCH      = 3'h0,
        OP_TABLE_READ = 3'h1,
        OP_DMOVE8     = 3'h2,
        OP_DMOVE16    = 3'h3,
        OP_RAM_IND    = 3'h4,
        OP_RAM_DIR    = 3'h5,
        OP_DPTR_LOAD  = 3'h6,
        OP_VERIFY     = 3'h7
    } msd_op_e;

    typedef enum logic [8:0]
    {
        ST_IDLE = 9'h001,
        ST_PTR  = 9'h002,
        ST_XSEL = 9'h004,
        ST_MEM  = 9'h008,
        ST_ROMA = 9'h010,
        ST_ROMD = 9'h020,
        ST_EXT  = 9'h040,
        ST_EXTR = 9'h080,
        ST_SFRW = 9'h100
    } msd_state_e;
endpackage : msd_pkg

// file: core/msd_ram.sv
// Single-port RAM with registered read data
module msd_ram #(
    parameter int W     = 8,
    parameter int DEPTH = 256,
    parameter int AW    = 8
) (
    input  wire logic          clk,
    input  wire logic          ce,
    input  wire logic          we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [W-1:0]  wdata,
    output logic      [W-1:0]  rdata
);
    logic [W-1:0] mem [DEPTH];

    always_ff @(posedge clk)
    begin
        if (ce)
        begin
            if (we)
            begin
                mem[addr] <= wdata;
            end
            rdata <= mem[addr];
        end
    end
endmodule : msd_ram

// file: core/msd_sync.sv
// Two-flop synchroniser for pin inputs
module msd_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta <= '0;
            q    <= '0;
        end
        else if (ce)
        begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule : msd_sync

// file: core/msd_decoder.sv
// Program and data space decoder with ROM protection
// Operation
// - The fetch-select pin decides if fetches below 8000H use on-chip ROM.
// - The ROM variant has 32 KB on-chip ROM; the ROM-less one fetches all.
// - Program space spans 64 KB, everything beyond the ROM is external.
// - Protection is a fixed mask option with no run-time way to clear it.
// - With protection, table reads run from external code cannot read ROM.
// - With protection, code run from ROM may table-read external memory.
// - The standard verify mode works only on unprotected parts.
// - A second verify mode reads ROM on protected and unprotected parts.
// - External data of 64 KB is reached by 8-bit and 16-bit indirection.
// - 8-bit data moves take their address from pointer zero or one.
// - Eight selectable 16-bit data pointers serve 16-bit data moves.
// - Data moves to F800..FFFF go to extension RAM or the bus per control.
// - The 2K x 8 extension RAM is reached only by external data moves.
// - The lower 32 bytes of RAM hold four banks of eight registers.
// - Upper RAM and the special register area are distinct blocks.
module msd_decoder #(
    parameter bit ROM_PRESENT = 1'b1,
    parameter bit ROM_PROTECT = 1'b0
) (
    input  wire logic             CLOCK,
    input  wire logic             RESETN,
    input  wire logic             CE,
    input  wire logic             EXT_FETCH_SELECT_N,
    input  wire logic             REQ,
    input  wire msd_pkg::msd_op_e OP,
    input  wire logic             WE,
    input  wire logic [15:0]      ADDR,
    input  wire logic [7:0]       WDATA,
    input  wire logic [2:0]       SEL,
    input  wire logic [1:0]       BANK,
    input  wire logic [7:0]       EXTENSION_PAGE,
    input  wire logic             SYS_CTRL_EXT_RAM_EN,
    input  wire logic [7:0]       ROM_DATA,
    input  wire logic             EXT_ACK,
    input  wire logic [7:0]       EXT_RDATA,
    input  wire logic [7:0]       SFR_RDATA,
    output logic                  BUSY,
    output logic                  DONE,
    output logic                  DENIED,
    output logic      [7:0]       RDATA,
    output logic                  ROM_RD,
    output logic      [14:0]      ROM_ADDR,
    output logic                  EXT_REQ,
    output logic                  EXT_CODE,
    output logic                  EXT_WE,
    output logic      [15:0]      EXT_ADDR,
    output logic      [7:0]       EXT_WDATA,
    output logic                  SFR_STB,
    output logic                  SFR_WE,
    output logic      [7:0]       SFR_ADDR,
    output logic      [7:0]       SFR_WDATA
);
    msd_pkg::msd_state_e state, next_state;
    logic        next_done, next_denied, next_rom_rd;
    logic [7:0]  next_rdata;
    logic [14:0] next_rom_addr;
    logic        next_ext_req, next_ext_code, next_ext_we;
    logic [15:0] next_ext_addr, addr_q, next_addr;
    logic [7:0]  next_ext_wdata, wdata_q, next_wdata;
    logic        next_sfr_stb, next_sfr_we;
    logic [7:0]  next_sfr_addr, next_sfr_wdata;
    logic        we_q, next_we, exec_int, next_exec_int;
    logic        from_ext_ram, next_from_ext_ram;
    logic [15:0] dptr [msd_pkg::NUM_DPTR];
    logic [15:0] next_dptr [msd_pkg::NUM_DPTR];
    logic [msd_pkg::SYNC_W-1:0] sync_q;
    logic        fsel_int, ack_q;
    logic [7:0]  ext_data_q, iram_q, ext_ram_q;
    logic        iram_we, ext_ram_we;
    logic [7:0]  iram_addr;
    logic [10:0] ext_ram_addr;

    // Internal fetch target only below the ROM limit with the pin high
    function automatic logic rom_hit(input logic [15:0] a, input logic f);
        rom_hit = ROM_PRESENT && f && (a < msd_pkg::ROM_LIMIT);
    endfunction : rom_hit

    function automatic logic ext_ram_hit(input logic [15:0] a);
        ext_ram_hit = (a >= msd_pkg::EXT_RAM_BASE);
    endfunction : ext_ram_hit

    // Bank register n sits at bank * 8 + n
    function automatic logic [7:0] reg_addr(input logic [1:0] b,
                                            input logic [2:0] n);
        reg_addr = {3'h0, b, n};
    endfunction : reg_addr

    msd_sync #(.W(msd_pkg::SYNC_W)) u_sync (
        .clk   (CLOCK),
        .rst_n (RESETN),
        .ce    (CE),
        .d     ({EXT_RDATA, EXT_ACK, EXT_FETCH_SELECT_N}),
        .q     (sync_q)
    );
    assign fsel_int   = sync_q[msd_pkg::SYNC_FSEL];
    assign ack_q      = sync_q[msd_pkg::SYNC_ACK];
    assign ext_data_q = sync_q[msd_pkg::SYNC_DATA +: 8];

    // Lower banks, upper RAM; special registers live outside
    msd_ram #(.W(8), .DEPTH(msd_pkg::IRAM_SIZE), .AW(msd_pkg::IRAM_AW))
    u_iram (
        .clk   (CLOCK),
        .ce    (CE),
        .we    (iram_we),
        .addr  (iram_addr),
        .wdata (WDATA),
        .rdata (iram_q)
    );

    msd_ram #(.W(8), .DEPTH(msd_pkg::EXT_RAM_SIZE),
              .AW(msd_pkg::EXT_RAM_AW))
    u_ext_ram (
        .clk   (CLOCK),
        .ce    (CE),
        .we    (ext_ram_we),
        .addr  (ext_ram_addr),
        .wdata (wdata_q),
        .rdata (ext_ram_q)
    );

    assign BUSY = (state != msd_pkg::ST_IDLE);

    always_comb
    begin
        next_state        = state;
        next_done         = 1'b0;
        next_denied       = 1'b0;
        next_rdata        = RDATA;
        next_rom_rd       = 1'b0;
        next_rom_addr     = ROM_ADDR;
        next_ext_req      = EXT_REQ;
        next_ext_code     = EXT_CODE;
        next_ext_we       = EXT_WE;
        next_ext_addr     = EXT_ADDR;
        next_ext_wdata    = EXT_WDATA;
        next_sfr_stb      = 1'b0;
        next_sfr_we       = SFR_WE;
        next_sfr_addr     = SFR_ADDR;
        next_sfr_wdata    = SFR_WDATA;
        next_addr         = addr_q;
        next_we           = we_q;
        next_wdata        = wdata_q;
        next_exec_int     = exec_int;
        next_from_ext_ram = from_ext_ram;
        next_dptr         = dptr;
        iram_we           = 1'b0;
        iram_addr         = ADDR[7:0];
        ext_ram_we        = 1'b0;
        ext_ram_addr      = addr_q[10:0];
        unique case (state)
            msd_pkg::ST_IDLE:
            begin
                if (REQ)
                begin
                    next_addr  = ADDR;
                    next_we    = WE;
                    next_wdata = WDATA;
                    unique case (OP)
                        msd_pkg::OP_FETCH:
                        begin
                            next_exec_int = rom_hit(ADDR, fsel_int);
                            if (rom_hit(ADDR, fsel_int))
                            begin
                                next_rom_rd   = 1'b1;
                                next_rom_addr = ADDR[14:0];
                                next_state    = msd_pkg::ST_ROMA;
                            end
                            else
                            begin
                                next_ext_req  = 1'b1;
                                next_ext_code = 1'b1;
                                next_ext_we   = 1'b0;
                                next_ext_addr = ADDR;
                                next_state    = msd_pkg::ST_EXT;
                            end
                        end
                        msd_pkg::OP_TABLE_READ:
                        begin
                            if (rom_hit(ADDR, fsel_int) && ROM_PROTECT &&
                                !exec_int)
                            begin
                                next_rdata  = msd_pkg::BLOCK_DATA;
                                next_denied = 1'b1;
                                next_done   = 1'b1;
                            end
                            else if (rom_hit(ADDR, fsel_int))
                            begin
                                next_rom_rd   = 1'b1;
                                next_rom_addr = ADDR[14:0];
                                next_state    = msd_pkg::ST_ROMA;
                            end
                            else
                            begin
                                next_ext_req  = 1'b1;
                                next_ext_code = 1'b1;
                                next_ext_we   = 1'b0;
                                next_ext_addr = ADDR;
                                next_state    = msd_pkg::ST_EXT;
                            end
                        end
                        msd_pkg::OP_VERIFY:
                        begin
                            if (!ROM_PRESENT || (!SEL[0] && ROM_PROTECT))
                            begin
                                next_rdata  = msd_pkg::BLOCK_DATA;
                                next_denied = 1'b1;
                                next_done   = 1'b1;
                            end
                            else
                            begin
                                next_rom_rd   = 1'b1;
                                next_rom_addr = ADDR[14:0];
                                next_state    = msd_pkg::ST_ROMA;
                            end
                        end
                        msd_pkg::OP_DMOVE8:
                        begin
                            iram_addr  = reg_addr(BANK, {2'h0, SEL[0]});
                            next_state = msd_pkg::ST_PTR;
                        end
                        msd_pkg::OP_DMOVE16:
                        begin
                            next_addr  = dptr[SEL];
                            next_state = msd_pkg::ST_XSEL;
                        end
                        msd_pkg::OP_DPTR_LOAD:
                        begin
                            next_dptr[SEL] = ADDR;
                            next_done      = 1'b1;
                        end
                        msd_pkg::OP_RAM_IND, msd_pkg::OP_RAM_DIR:
                        begin
                            if (OP == msd_pkg::OP_RAM_DIR &&
                                ADDR[7:0] >= msd_pkg::SFR_BASE)
                            begin
                                next_sfr_stb   = 1'b1;
                                next_sfr_we    = WE;
                                next_sfr_addr  = ADDR[7:0];
                                next_sfr_wdata = WDATA;
                                next_state     = msd_pkg::ST_SFRW;
                            end
                            else
                            begin
                                iram_we           = WE;
                                next_from_ext_ram = 1'b0;
                                next_done         = WE;
                                next_state = WE ? msd_pkg::ST_IDLE
                                                : msd_pkg::ST_MEM;
                            end
                        end
                    endcase
                end
            end
            msd_pkg::ST_PTR:
            begin
                next_addr  = {EXTENSION_PAGE, iram_q};
                next_state = msd_pkg::ST_XSEL;
            end
            msd_pkg::ST_XSEL:
            begin
                if (ext_ram_hit(addr_q) && SYS_CTRL_EXT_RAM_EN)
                begin
                    ext_ram_we        = we_q;
                    next_from_ext_ram = 1'b1;
                    next_done         = we_q;
                    next_state = we_q ? msd_pkg::ST_IDLE : msd_pkg::ST_MEM;
                end
                else
                begin
                    next_ext_req   = 1'b1;
                    next_ext_code  = 1'b0;
                    next_ext_we    = we_q;
                    next_ext_addr  = addr_q;
                    next_ext_wdata = wdata_q;
                    next_state     = msd_pkg::ST_EXT;
                end
            end
            msd_pkg::ST_MEM:
            begin
                next_rdata = from_ext_ram ? ext_ram_q : iram_q;
                next_done  = 1'b1;
                next_state = msd_pkg::ST_IDLE;
            end
            msd_pkg::ST_ROMA:
            begin
                next_state = msd_pkg::ST_ROMD;
            end
            msd_pkg::ST_ROMD:
            begin
                next_rdata = ROM_DATA;
                next_done  = 1'b1;
                next_state = msd_pkg::ST_IDLE;
            end
            msd_pkg::ST_EXT:
            begin
                if (ack_q)
                begin
                    next_rdata   = EXT_WE ? RDATA : ext_data_q;
                    next_ext_req = 1'b0;
                    next_state   = msd_pkg::ST_EXTR;
                end
            end
            msd_pkg::ST_EXTR:
            begin
                if (!ack_q)
                begin
                    next_done  = 1'b1;
                    next_state = msd_pkg::ST_IDLE;
                end
            end
            msd_pkg::ST_SFRW:
            begin
                next_rdata = SFR_WE ? RDATA : SFR_RDATA;
                next_done  = 1'b1;
                next_state = msd_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLOCK or negedge RESETN)
    begin
        if (!RESETN)
        begin
            state        <= msd_pkg::ST_IDLE;
            DONE         <= 1'b0;
            DENIED       <= 1'b0;
            RDATA        <= 8'h00;
            ROM_RD       <= 1'b0;
            ROM_ADDR     <= 15'h0000;
            EXT_REQ      <= 1'b0;
            EXT_CODE     <= 1'b0;
            EXT_WE       <= 1'b0;
            EXT_ADDR     <= 16'h0000;
            EXT_WDATA    <= 8'h00;
            SFR_STB      <= 1'b0;
            SFR_WE       <= 1'b0;
            SFR_ADDR     <= 8'h00;
            SFR_WDATA    <= 8'h00;
            addr_q       <= 16'h0000;
            we_q         <= 1'b0;
            wdata_q      <= 8'h00;
            exec_int     <= 1'b0;
            from_ext_ram <= 1'b0;
            dptr         <= '{default: 16'h0000};
        end
        else if (CE)
        begin
            state        <= next_state;
            DONE         <= next_done;
            DENIED       <= next_denied;
            RDATA        <= next_rdata;
            ROM_RD       <= next_rom_rd;
            ROM_ADDR     <= next_rom_addr;
            EXT_REQ      <= next_ext_req;
            EXT_CODE     <= next_ext_code;
            EXT_WE       <= next_ext_we;
            EXT_ADDR     <= next_ext_addr;
            EXT_WDATA    <= next_ext_wdata;
            SFR_STB      <= next_sfr_stb;
            SFR_WE       <= next_sfr_we;
            SFR_ADDR     <= next_sfr_addr;
            SFR_WDATA    <= next_sfr_wdata;
            addr_q       <= next_addr;
            we_q         <= next_we;
            wdata_q      <= next_wdata;
            exec_int     <= next_exec_int;
            from_ext_ram <= next_from_ext_ram;
            dptr         <= next_dptr;
        end
    end

    logic idle_req;
    assign idle_req = (state == msd_pkg::ST_IDLE) && REQ;

    a_fetch_rom_route: assert property (@(posedge CLOCK)
        disable iff (!RESETN || !CE)
        idle_req && OP == msd_pkg::OP_FETCH && rom_hit(ADDR, fsel_int)
        |=> ROM_RD && ROM_ADDR == $past(ADDR[14:0]) ##2 DONE)
        else $error("internal fetch did not read the ROM");
    a_romless_no_rom: assert property (@(posedge CLOCK)
        disable iff (!RESETN)
        !ROM_PRESENT |-> !ROM_RD)
        else $error("ROM read on a ROM-less part");
    a_high_fetch_ext: assert property (@(posedge CLOCK)
        disable iff (!RESETN || !CE)
        idle_req && OP == msd_pkg::OP_FETCH && ADDR >= msd_pkg::ROM_LIMIT
        |=> EXT_REQ && EXT_CODE && EXT_ADDR == $past(ADDR))
        else $error("high fetch not sent to the bus");
    a_table_blocked: assert property (@(posedge CLOCK)
        disable iff (!RESETN || !CE)
        idle_req && OP == msd_pkg::OP_TABLE_READ && ROM_PROTECT &&
        !exec_int && rom_hit(ADDR, fsel_int)
        |=> DENIED && DONE && !ROM_RD && RDATA == msd_pkg::BLOCK_DATA)
        else $error("protected ROM read from external code");
    a_table_int_ext: assert property (@(posedge CLOCK)
        disable iff (!RESETN || !CE)
        idle_req && OP == msd_pkg::OP_TABLE_READ && exec_int &&
        ADDR >= msd_pkg::ROM_LIMIT
        |=> EXT_REQ && EXT_CODE && !DENIED)
        else $error("table read from ROM code to bus refused");
    a_verify_std_off: assert property (@(posedge CLOCK)
        disable iff (!RESETN || !CE)
        idle_req && OP == msd_pkg::OP_VERIFY && !SEL[0] && ROM_PROTECT
        |=> DENIED && !ROM_RD)
        else $error("standard verify allowed on protected part");
    a_verify_alt_ok: assert property (@(posedge CLOCK)
        disable iff (!RESETN || !CE)
        idle_req && OP == msd_pkg::OP_VERIFY && SEL[0] && ROM_PRESENT
        |=> ROM_RD && !DENIED ##2 DONE)
        else $error("second verify mode refused");
    a_ptr_address: assert property (@(posedge CLOCK)
        disable iff (!RESETN || !CE)
        state == msd_pkg::ST_PTR
        |=> addr_q == {$past(EXTENSION_PAGE), $past(iram_q)})
        else $error("8-bit data address not from pointer");
    a_ext_ram_hit: assert property (@(posedge CLOCK)
        disable iff (!RESETN || !CE)
        state == msd_pkg::ST_XSEL && ext_ram_hit(addr_q) &&
        SYS_CTRL_EXT_RAM_EN && !we_q
        |=> !EXT_REQ && state == msd_pkg::ST_MEM ##1 DONE)
        else $error("extension RAM hit went elsewhere");
    a_ext_ram_off: assert property (@(posedge CLOCK)
        disable iff (!RESETN || !CE)
        state == msd_pkg::ST_XSEL && !(ext_ram_hit(addr_q) &&
        SYS_CTRL_EXT_RAM_EN)
        |-> !ext_ram_we ##1 EXT_REQ && !EXT_CODE)
        else $error("deselected range not sent to the bus");
endmodule : msd_decoder

// file: bench/msd_bus_model.sv
// External program and data memory answering the four-phase bus
module msd_bus_model
(
    input  wire logic        clk,
    input  wire logic        ext_req,
    input  wire logic        ext_code,
    input  wire logic        ext_we,
    input  wire logic [15:0] ext_addr,
    input  wire logic [7:0]  ext_wdata,
    output logic             ext_ack,
    output logic      [7:0]  ext_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  mem [int];
    logic [15:0] last_addr;
    logic        last_code;
    int          seen = 0;
    int          seed = 7;
    initial
    begin
        ext_ack = 1'b0;
        ext_rdata = 8'h00;
        forever
        begin
            @(posedge clk);
            if (ext_req)
            begin
                repeat ($random(seed) & 3) @(posedge clk);
                last_addr = ext_addr;
                last_code = ext_code;
                seen++;
                if (ext_we)
                    mem[ext_addr] = ext_wdata;
                ext_rdata <= mem.exists(ext_addr) ? mem[ext_addr]
                                                  : ext_addr[7:0] ^ 8'hC3;
                // Data settles a cycle before acknowledge rises
                @(posedge clk);
                ext_ack <= 1'b1;
                while (ext_req) @(posedge clk);
                ext_ack <= 1'b0;
                @(posedge clk);
                ext_rdata <= ~ext_rdata;
            end
        end
    end
endmodule : msd_bus_model

// file: bench/memory_space_decoder_bench.sv
// Self-checking bench for the memory space decoder
module memory_space_decoder_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLOCK = 0, RESETN = 0, PIN = 1, REQ = 0, WE = 0, XEN = 0, den;
    logic [15:0] ADDR = 0, EXT_ADDR, a;
    logic [7:0]  WDATA = 0, PAGE = 0, ROM_DATA = 0, RDATA, rd, v, RDATA2, rd2;
    logic [7:0]  EXT_WDATA, EXT_RDATA;
    logic [14:0] ROM_ADDR;
    logic [2:0]  SEL = 0;
    logic [1:0]  BANK = 0;
    logic        BUSY, DONE, DENIED, ROM_RD, EXT_REQ, EXT_CODE, EXT_WE;
    logic        EXT_ACK, DONE2, DENIED2, den2;
    msd_pkg::msd_op_e OP = msd_pkg::OP_FETCH;
    int failures = 0, checks_done = 0, seed = 68115, n0;

    msd_decoder DUT (.CLOCK(CLOCK), .RESETN(RESETN), .CE(1'b1),
        .EXT_FETCH_SELECT_N(PIN), .REQ(REQ), .OP(OP), .WE(WE),
        .ADDR(ADDR), .WDATA(WDATA), .SEL(SEL), .BANK(BANK),
        .EXTENSION_PAGE(PAGE), .SYS_CTRL_EXT_RAM_EN(XEN),
        .ROM_DATA(ROM_DATA), .EXT_ACK(EXT_ACK), .EXT_RDATA(EXT_RDATA),
        .SFR_RDATA(8'h3C), .BUSY(BUSY), .DONE(DONE), .DENIED(DENIED),
        .RDATA(RDATA), .ROM_RD(ROM_RD), .ROM_ADDR(ROM_ADDR),
        .EXT_REQ(EXT_REQ), .EXT_CODE(EXT_CODE), .EXT_WE(EXT_WE),
        .EXT_ADDR(EXT_ADDR), .EXT_WDATA(EXT_WDATA), .SFR_STB(),
        .SFR_WE(), .SFR_ADDR(), .SFR_WDATA());
    msd_decoder #(.ROM_PROTECT(1'b1)) DUT_LOCKED (.CLOCK(CLOCK),
        .RESETN(RESETN), .CE(1'b1), .EXT_FETCH_SELECT_N(PIN), .REQ(REQ),
        .OP(OP), .WE(WE), .ADDR(ADDR), .WDATA(WDATA), .SEL(SEL),
        .BANK(BANK), .EXTENSION_PAGE(PAGE), .SYS_CTRL_EXT_RAM_EN(XEN),
        .ROM_DATA(ROM_DATA), .EXT_ACK(EXT_ACK), .EXT_RDATA(EXT_RDATA),
        .SFR_RDATA(8'h3C), .BUSY(), .DONE(DONE2), .DENIED(DENIED2),
        .RDATA(RDATA2), .ROM_RD(), .ROM_ADDR(), .EXT_REQ(), .EXT_CODE(),
        .EXT_WE(), .EXT_ADDR(), .EXT_WDATA(), .SFR_STB(), .SFR_WE(),
        .SFR_ADDR(), .SFR_WDATA());
    msd_bus_model partner (.clk(CLOCK), .ext_req(EXT_REQ),
        .ext_code(EXT_CODE), .ext_we(EXT_WE), .ext_addr(EXT_ADDR),
        .ext_wdata(EXT_WDATA), .ext_ack(EXT_ACK), .ext_rdata(EXT_RDATA));

    always #5 CLOCK = ~CLOCK;
    // ROM array answers the cycle after a read strobe
    always @(posedge CLOCK)
        if (ROM_RD)
            ROM_DATA <= rom_val({1'b0, ROM_ADDR});

    function automatic logic [7:0] rom_val(input logic [15:0] x);
        return x[7:0] ^ x[14:8];
    endfunction : rom_val

    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wrap_up();
        if (failures == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : wrap_up

    task automatic run(input msd_pkg::msd_op_e op, input logic w,
                       input logic [15:0] ad, input logic [7:0] d,
                       input logic [2:0] s);
        int n;
        n = 0;
        n0 = partner.seen;
        @(posedge CLOCK);
        OP <= op;
        WE <= w;
        ADDR <= ad;
        WDATA <= d;
        SEL <= s;
        REQ <= 1'b1;
        @(posedge CLOCK);
        REQ <= 1'b0;
        do
        begin
            @(negedge CLOCK);
            n++;
            if (DONE2 === 1'b1)
                den2 = DENIED2;
        end
        while (DONE !== 1'b1 && n < 400);
        if (n >= 400)
        begin
            failures++;
            wrap_up();
        end
        rd = RDATA;
        den = DENIED;
        rd2 = RDATA2;
    endtask : run

    initial
    begin
        #200us;
        failures++;
        wrap_up();
    end

    initial
    begin
        repeat (10) @(posedge CLOCK);
        RESETN <= 1'b1;
        for (int p = 1; p >= 0; p--)
        begin
            PIN <= p[0];
            repeat (4) @(posedge CLOCK);
            for (int i = 0; i < 4; i++)
            begin
                a = 16'({16'hFFFF, 16'h8000, 16'h7FFF, 16'h0000} >> 16 * i);
                v = (p == 1 && a < 16'h8000) ? rom_val(a) : a[7:0] ^ 8'hC3;
                run(msd_pkg::OP_FETCH, 1'b0, a, 8'h00, 3'h0);
                check("fetch data", 16'(rd), 16'(v));
                check("fetch on bus", 16'(partner.seen - n0),
                      16'(p == 0 || a >= 16'h8000));
            end
        end
        PIN <= 1'b1;
        repeat (4) @(posedge CLOCK);
        run(msd_pkg::OP_FETCH, 1'b0, 16'h0100, 8'h00, 3'h0);
        run(msd_pkg::OP_TABLE_READ, 1'b0, 16'h9123, 8'h00, 3'h0);
        check("table read far", 16'(rd), 16'h23 ^ 16'hC3);
        check("table space", 16'(partner.last_code), 16'h1);
        run(msd_pkg::OP_TABLE_READ, 1'b0, 16'h1234, 8'h00, 3'h0);
        check("table read rom", 16'(rd), 16'(rom_val(16'h1234)));
        for (int m = 0; m < 2; m++)
        begin
            run(msd_pkg::OP_VERIFY, 1'b0, 16'h0ABC, 8'h00, 3'(m));
            check("verify refused", 16'(den), 16'h0);
            check("verify data", 16'(rd), 16'(rom_val(16'h0ABC)));
            check("locked verify", 16'(den2), 16'(m == 0));
        end
        run(msd_pkg::OP_FETCH, 1'b0, 16'h9000, 8'h00, 3'h0);
        run(msd_pkg::OP_TABLE_READ, 1'b0, 16'h1234, 8'h00, 3'h0);
        check("locked table", 16'(den2), 16'h1);
        check("locked data", 16'(rd2), 16'h0);
        run(msd_pkg::OP_RAM_DIR, 1'b0, 16'h0090, 8'h00, 3'h0);
        check("special area", 16'(rd), 16'h3C);
        run(msd_pkg::OP_RAM_IND, 1'b1, 16'h0090, 8'h77, 3'h0);
        run(msd_pkg::OP_RAM_IND, 1'b0, 16'h0090, 8'h00, 3'h0);
        check("upper ram", 16'(rd), 16'h77);
        for (int i = 0; i < 8; i++)
        begin
            BANK <= 2'($random(seed));
            PAGE <= 8'($random(seed)) & 8'hEF;
            v = 8'($random(seed));
            @(posedge CLOCK);
            run(msd_pkg::OP_RAM_DIR, 1'b1, 16'({BANK, 2'b00, i[0]}), v, 3'h0);
            run(msd_pkg::OP_DMOVE8, 1'b0, 16'h0000, 8'h00, 3'(i[0]));
            check("page pointer", partner.last_addr, {PAGE, v});
            check("short move", 16'(rd), 16'(v ^ 8'hC3));
        end
        for (int i = 0; i < 16; i++)
        begin
            a = 16'($random(seed));
            a = i[0] ? a | 16'hF800 : a & 16'h7FFF;
            v = 8'($random(seed));
            XEN <= i[1];
            run(msd_pkg::OP_DPTR_LOAD, 1'b0, a, 8'h00, 3'(i));
            run(msd_pkg::OP_DMOVE16, 1'b1, 16'h0000, v, 3'(i));
            run(msd_pkg::OP_DMOVE16, 1'b0, 16'h0000, 8'h00, 3'(i));
            check("long move", 16'(rd), 16'(v));
            check("bus cycles", 16'(partner.seen - n0),
                  16'(!(i[0] && i[1])));
        end
        wrap_up();
    end
endmodule : memory_space_decoder_bench
